// ===== pdc_regs.vh
// Constants for the packet DRAM command path
`ifndef PDC_REGS_VH
`define PDC_REGS_VH
// ----------------------------------------
// Register offsets (plain port)
// ----------------------------------------
`define PDC_ADDR_DEVNUM 4'h0
`define PDC_ADDR_REFROW 4'h1
`define PDC_ADDR_STATUS 4'h2
`define PDC_ADDR_OPENLO 4'h3
`define PDC_ADDR_OPENHI 4'h4
`define PDC_ADDR_CTRL 4'h5
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDC_DEVNUM_RST 5'h00
`define PDC_REFROW_RST 9'h000
// ----------------------------------------
// Row packet fields (24 bits)
// ----------------------------------------
`define PDC_ROW_FT 23
`define PDC_ROW_FF 22
`define PDC_ROW_SEL 21
`define PDC_ROW_DEV_HI 20
`define PDC_ROW_DEV_LO 17
`define PDC_ROW_BANK_HI 16
`define PDC_ROW_BANK_LO 12
`define PDC_ROW_ADDR_HI 8
`define PDC_ROW_OP_HI 10
// ----------------------------------------
// Column packet fields (23 bits + 17 bits)
// ----------------------------------------
`define PDC_COL_START 22
`define PDC_COL_DEV_HI 21
`define PDC_COL_DEV_LO 17
`define PDC_COL_BANK_HI 16
`define PDC_COL_BANK_LO 12
`define PDC_COL_COL_HI 11
`define PDC_COL_COL_LO 5
`define PDC_COL_OP_HI 3
`define PDC_CMP_SEL 16
`define PDC_CMP_DEV_HI 15
`define PDC_CMP_DEV_LO 11
`define PDC_CMP_BANK_HI 10
`define PDC_CMP_BANK_LO 6
`define PDC_CMP_OP_HI 4
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define PDC_ROP_CLOSE 11'h001
`define PDC_ROP_REFRESH 11'h002
`define PDC_CCMD_IDLE 4'h0
`define PDC_CCMD_READ 4'h1
`define PDC_CCMD_WRITE 4'h2
`define PDC_CCMD_IDLE_CL 4'h4
`define PDC_CCMD_READ_CL 4'h5
`define PDC_CCMD_WRITE_CL 4'h6
`define PDC_XCMD_CLOSE 5'h01
`endif

// ===== pdc_lane_shift.v
// Serial-to-parallel collector for request pins
`timescale 1ns/1ps
`default_nettype none
module pdc_lane_shift #(
    parameter PINS = 3,
    parameter BEATS = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Pins, active-low on the channel
    input wire [PINS-1:0] pinsN,
    // Collected word, newest beat in low bits
    output reg [PINS*BEATS-1:0] word
);
    // Shift one beat per cycle; pins inverted to logic sense
    always @(posedge core_clk) begin
        if (!rst_b) begin
            word <= {PINS*BEATS{1'b0}};
        end else begin
            word <= {word[PINS*BEATS-PINS-1:0], ~pinsN};
        end
    end
endmodule // pdc_lane_shift
`default_nettype wire

// ===== pdc_wide_path.v
// Lane (de)multiplexer to one 8-beat wide data path
`timescale 1ns/1ps
`default_nettype none
module pdc_wide_path #(
    parameter LW = 9
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Beat phase 0..7
    input wire [2:0] phase,
    // Receive side
    input wire [LW-1:0] laneInN,
    output reg [8*LW-1:0] rxWord,
    // Transmit side
    input wire load,
    input wire [8*LW-1:0] txWord,
    output reg [LW-1:0] laneOutN
);
    reg [8*LW-1:0] txShift;
    // Gather receive beats into wide word
    always @(posedge core_clk) begin
        if (!rst_b) begin
            rxWord <= {8*LW{1'b0}};
        end else begin
            rxWord[phase*LW +: LW] <= ~laneInN;
        end
    end
    // Serialise, earliest byte in low bits; idle lanes read logic zero
    always @(posedge core_clk) begin
        if (!rst_b) begin
            txShift <= {8*LW{1'b0}};
            laneOutN <= {LW{1'b1}};
        end else begin
            if (load) begin
                txShift <= {{LW{1'b0}}, txWord[8*LW-1:LW]};
                laneOutN <= ~txWord[LW-1:0];
            end else begin
                txShift <= {{LW{1'b0}}, txShift[8*LW-1:LW]};
                laneOutN <= ~txShift[LW-1:0];
            end
        end
    end
endmodule // pdc_wide_path
`default_nettype wire

// ===== pdc_command_path.v
// Command and data path of the packet DRAM device
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.vh"
module pdc_command_path #(
    parameter WIDE18 = 0,
    parameter ROWS = 512,
    parameter COLS = 128
) (
    // Clock and reset
    input wire core_clk,
    input wire rst_b,
    // Request pins, active low
    input wire [2:0] rowPinsN,
    input wire [4:0] colPinsN,
    // Data lanes, active low, three-signal pins
    input wire [8:0] dataLaneAInN,
    output wire [8:0] dataLaneAOutN,
    output wire [8:0] dataLaneAOeN,
    input wire [8:0] dataLaneBInN,
    output wire [8:0] dataLaneBOutN,
    output wire [8:0] dataLaneBOeN,
    // Register port
    input wire [3:0] regAddr,
    input wire [15:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [15:0] regRdData
);
    localparam LW = 9;
    localparam DW = 16 * LW;
    localparam ROW_AW = 9;
    localparam COL_AW = 7;
    localparam MEM_AW = 5 + ROW_AW + COL_AW;
    // ----------------------------------------
    // Packet timing and collection
    // ----------------------------------------
    reg [2:0] phase;
    wire [23:0] rowWord;
    wire [39:0] colWord;
    // Eight beats per packet; phase 7 ends a packet
    always @(posedge core_clk) begin
        if (!rst_b) begin
            phase <= 3'h0;
        end else begin
            phase <= phase + 3'h1;
        end
    end
    wire packetEnd = (phase == 3'h7);
    pdc_lane_shift #(.PINS(3), .BEATS(8)) rowShift (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pinsN(rowPinsN),
        .word(rowWord)
    );
    pdc_lane_shift #(.PINS(5), .BEATS(8)) colShift (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pinsN(colPinsN),
        .word(colWord)
    );
    // ----------------------------------------
    // Wide data paths
    // ----------------------------------------
    wire [8*LW-1:0] rxA;
    wire [8*LW-1:0] rxB;
    reg [DW-1:0] readData;
    reg txLoad;
    wire [8:0] outA;
    wire [8:0] outB;
    pdc_wide_path #(.LW(LW)) pathA (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .phase(phase),
        .laneInN(dataLaneAInN),
        .rxWord(rxA),
        .load(txLoad),
        .txWord(readData[8*LW-1:0]),
        .laneOutN(outA)
    );
    pdc_wide_path #(.LW(LW)) pathB (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .phase(phase),
        .laneInN(dataLaneBInN),
        .rxWord(rxB),
        .load(txLoad),
        .txWord(readData[DW-1:8*LW]),
        .laneOutN(outB)
    );
    // Drive window covers the eight beats after load
    reg [3:0] txBeats;
    always @(posedge core_clk) begin
        if (!rst_b) begin
            txBeats <= 4'h0;
        end else if (txLoad) begin
            txBeats <= 4'h8;
        end else if (txBeats != 4'h0) begin
            txBeats <= txBeats - 4'h1;
        end
    end
    wire drive = (txBeats != 4'h0);
    // Ninth bit left floating in 16-bit mode
    wire top = drive && (WIDE18 != 0);
    assign dataLaneAOutN = outA;
    assign dataLaneBOutN = outB;
    assign dataLaneAOeN = {~top, {8{~drive}}};
    assign dataLaneBOeN = {~top, {8{~drive}}};
    // ----------------------------------------
    // Device number and refresh pointer
    // ----------------------------------------
    reg [4:0] deviceNumber;
    reg [ROW_AW-1:0] refreshRowPointer;
    // ----------------------------------------
    // Row packet decode
    // ----------------------------------------
    wire ft = rowWord[`PDC_ROW_FT];
    wire ff = rowWord[`PDC_ROW_FF];
    wire [4:0] rowDev = {ft, rowWord[`PDC_ROW_DEV_HI:`PDC_ROW_DEV_LO]};
    wire [4:0] rowBank = rowWord[`PDC_ROW_BANK_HI:`PDC_ROW_BANK_LO];
    wire [ROW_AW-1:0] rowAddr = rowWord[`PDC_ROW_ADDR_HI:0];
    wire [10:0] rowOp = rowWord[`PDC_ROW_OP_HI:0];
    // Broadcast when both framing bits set; none means no packet
    wire deviceHit = packetEnd && ((ft && ff) || ((ft ^ ff) && rowDev == deviceNumber));
    wire rowOpen = deviceHit && rowWord[`PDC_ROW_SEL];
    wire rowOper = deviceHit && !rowWord[`PDC_ROW_SEL];
    wire rowClose = rowOper && rowOp == `PDC_ROP_CLOSE;
    wire rowRefresh = rowOper && rowOp == `PDC_ROP_REFRESH;
    // ----------------------------------------
    // Column packet decode
    // ----------------------------------------
    wire [22:0] colCmd = colWord[39:17];
    wire [16:0] colCmp = colWord[16:0];
    wire colFrame = packetEnd && colCmd[`PDC_COL_START];
    wire [4:0] colDev = colCmd[`PDC_COL_DEV_HI:`PDC_COL_DEV_LO];
    wire [4:0] colBank = colCmd[`PDC_COL_BANK_HI:`PDC_COL_BANK_LO];
    wire [COL_AW-1:0] colAddr = colCmd[`PDC_COL_COL_HI:`PDC_COL_COL_LO];
    wire [3:0] colOp = colCmd[`PDC_COL_OP_HI:0];
    wire colMine = colFrame && colDev == deviceNumber;
    wire isRead = colOp == `PDC_CCMD_READ || colOp == `PDC_CCMD_READ_CL;
    wire isWrite = colOp == `PDC_CCMD_WRITE || colOp == `PDC_CCMD_WRITE_CL;
    wire isIdle = colOp == `PDC_CCMD_IDLE || colOp == `PDC_CCMD_IDLE_CL;
    wire autoClose = colOp[2];
    wire maskPkt = colFrame && colCmp[`PDC_CMP_SEL];
    wire extPkt = colFrame && !colCmp[`PDC_CMP_SEL];
    wire extClose = extPkt && colCmp[`PDC_CMP_DEV_HI:`PDC_CMP_DEV_LO] == deviceNumber
        && colCmp[`PDC_CMP_OP_HI:0] == `PDC_XCMD_CLOSE;
    wire [4:0] extBank = colCmp[`PDC_CMP_BANK_HI:`PDC_CMP_BANK_LO];
    // ----------------------------------------
    // Bank state: open flags and open rows
    // ----------------------------------------
    reg [31:0] bankOpen;
    reg [ROW_AW-1:0] openRow [0:31];
    reg [31:0] next_bankOpen;
    wire [4:0] lowNb = rowBank - 5'h01;
    wire [4:0] highNb = rowBank + 5'h01;
    // Neighbours sharing amps; banks 15/16 and the ends share none
    wire nbBusy = (rowBank != 5'd0 && rowBank != 5'd16 && bankOpen[lowNb])
        || (rowBank != 5'd15 && rowBank != 5'd31 && bankOpen[highNb]);
    // Close from row packet, auto-close, or extended packet
    always @* begin
        next_bankOpen = bankOpen;
        if (rowClose) begin
            next_bankOpen[rowBank] = 1'b0;
        end
        if (colMine && autoClose) begin
            next_bankOpen[colBank] = 1'b0;
        end
        if (extClose) begin
            next_bankOpen[extBank] = 1'b0;
        end
        if ((rowOpen || rowRefresh) && !nbBusy) begin
            next_bankOpen[rowBank] = 1'b1;
        end
    end
    // Open is refused when a neighbour holds the shared amps
    always @(posedge core_clk) begin
        if (!rst_b) begin
            bankOpen <= 32'h0000_0000;
        end else begin
            bankOpen <= next_bankOpen;
        end
    end
    always @(posedge core_clk) begin
        if ((rowOpen || rowRefresh) && !nbBusy) begin
            openRow[rowBank] <= rowRefresh ? refreshRowPointer : rowAddr;
        end
    end
    // ----------------------------------------
    // Core array and write buffer
    // ----------------------------------------
    reg [DW-1:0] core [0:(1<<MEM_AW)-1];
    reg wbFull;
    reg [4:0] wbBank;
    reg [COL_AW-1:0] wbCol;
    reg [DW-1:0] wbData;
    reg [15:0] wbMask;
    // Retire while its bank is open on any command elsewhere, or write/idle here, never own read
    wire retire = wbFull && colFrame && (!colMine || isWrite || isIdle)
        && bankOpen[wbBank];
    wire [MEM_AW-1:0] wbAddr = {wbBank, openRow[wbBank], wbCol};
    wire [MEM_AW-1:0] rdAddr = {colBank, openRow[colBank], colAddr};
    wire [DW-1:0] rxData = {rxB, rxA};
    integer i;
    // Byte-masked merge into the addressed dualoct
    always @(posedge core_clk) begin
        if (retire) begin
            for (i = 0; i < 16; i = i + 1) begin
                if (wbMask[i]) begin
                    core[wbAddr][i*LW +: LW] <= wbData[i*LW +: LW];
                end
            end
        end
    end
    // Capture on write; a new write after retire refills the buffer
    always @(posedge core_clk) begin
        if (!rst_b) begin
            wbFull <= 1'b0;
            wbBank <= 5'h00;
            wbCol <= {COL_AW{1'b0}};
            wbData <= {DW{1'b0}};
            wbMask <= 16'hFFFF;
        end else begin
            if (colMine && isWrite) begin
                wbFull <= 1'b1;
                wbBank <= colBank;
                wbCol <= colAddr;
                wbData <= rxData;
                wbMask <= maskPkt ? {colCmp[7:0], colCmp[15:8]} : 16'hFFFF;
            end else if (retire) begin
                wbFull <= 1'b0;
            end
        end
    end
    // Read from open bank onto both lanes
    always @(posedge core_clk) begin
        if (!rst_b) begin
            readData <= {DW{1'b0}};
            txLoad <= 1'b0;
        end else begin
            txLoad <= colMine && isRead && bankOpen[colBank];
            if (colMine && isRead) begin
                readData <= core[rdAddr];
            end
        end
    end
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Refresh advances the pointer after the top bank
    always @(posedge core_clk) begin
        if (!rst_b) begin
            deviceNumber <= `PDC_DEVNUM_RST;
            refreshRowPointer <= `PDC_REFROW_RST;
        end else begin
            if (regWr && regAddr == `PDC_ADDR_DEVNUM) begin
                deviceNumber <= regWrData[4:0];
            end
            if (rowRefresh && rowBank == 5'h1F) begin
                refreshRowPointer <= refreshRowPointer + 9'h001;
            end else if (regWr && regAddr == `PDC_ADDR_REFROW) begin
                refreshRowPointer <= regWrData[ROW_AW-1:0];
            end
        end
    end
    // Read data one cycle after strobe, zero otherwise
    always @(posedge core_clk) begin
        if (!rst_b) begin
            regRdData <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                `PDC_ADDR_DEVNUM: regRdData <= {11'h000, deviceNumber};
                `PDC_ADDR_REFROW: regRdData <= {7'h00, refreshRowPointer};
                `PDC_ADDR_STATUS: regRdData <= {14'h0000, drive, wbFull};
                `PDC_ADDR_OPENLO: regRdData <= bankOpen[15:0];
                `PDC_ADDR_OPENHI: regRdData <= bankOpen[31:16];
                default: regRdData <= 16'h0000;
            endcase
        end else begin
            regRdData <= 16'h0000;
        end
    end
endmodule // pdc_command_path
`default_nettype wire

// ===== pdc_command_path_monitor.sv
// Port-level checker for the packet DRAM command path
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.vh"
module pdc_command_path_monitor #(
    parameter WIDE18 = 0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Channel pins
    input wire logic [4:0] colPinsN,
    input wire logic [8:0] dataLaneAOutN,
    input wire logic [8:0] dataLaneAOeN,
    input wire logic [8:0] dataLaneBOutN,
    input wire logic [8:0] dataLaneBOeN,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdData
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic [4:0] sinceCol;
    // Cycles since an active column beat; saturates so idle never wraps to look recent
    always @(posedge core_clk) begin
        if (!rst_b)
            sinceCol <= 5'h1F;
        else if (colPinsN != 5'h1F)
            sinceCol <= 5'h00;
        else if (sinceCol != 5'h1F)
            sinceCol <= sinceCol + 5'h01;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_NINTH_BIT_UNUSED:
        assert property ((WIDE18 == 0) |-> (dataLaneAOeN[8] && dataLaneBOeN[8]))
        else $error("Ninth lane bit driven in 16-bit mode");
    AST_LANES_PAIRED:
        assert property (dataLaneAOeN[7:0] == dataLaneBOeN[7:0])
        else $error("Lanes A and B not driven together");
    AST_BYTE_WHOLE:
        assert property (dataLaneAOeN[7:0] == 8'hFF || dataLaneAOeN[7:0] == 8'h00)
        else $error("Lane byte partly driven");
    AST_BURST_EIGHT:
        assert property ($fell(dataLaneAOeN[0]) |-> (!dataLaneAOeN[0]) [*8])
        else $error("Read burst shorter than eight beats");
    AST_IDLE_RELEASED:
        assert property (dataLaneAOeN[0] && dataLaneBOeN[0]
            |-> dataLaneAOutN == 9'h1FF && dataLaneBOutN == 9'h1FF)
        else $error("Idle lanes not at logic zero");
    AST_RDDATA_QUIET:
        assert property (!$past(regRd) |-> regRdData == 16'h0000)
        else $error("Read data outside its cycle");
    AST_DEVNUM_ECHO:
        assert property (regWr && regAddr == `PDC_ADDR_DEVNUM
            ##1 regRd && regAddr == `PDC_ADDR_DEVNUM
            |=> regRdData == {11'h000, $past(regWrData[4:0], 2)})
        else $error("Device number not echoed");
    AST_UNMAPPED_ZERO:
        assert property (regRd && regAddr > `PDC_ADDR_CTRL |=> regRdData == 16'h0000)
        else $error("Unmapped read not zero");
    AST_DRIVE_FOLLOWS_CMD:
        assert property ($fell(dataLaneAOeN[0]) |-> sinceCol <= 5'd14)
        else $error("Lanes driven without a column packet");
endmodule // pdc_command_path_monitor

bind pdc_command_path pdc_command_path_monitor #(.WIDE18(WIDE18)) mon_u (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .colPinsN(colPinsN),
    .dataLaneAOutN(dataLaneAOutN),
    .dataLaneAOeN(dataLaneAOeN),
    .dataLaneBOutN(dataLaneBOutN),
    .dataLaneBOeN(dataLaneBOeN),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData)
);
`default_nettype wire

// ===== pdc_channel_master.sv
// Channel master model driving request pins and its share of the data lanes
`timescale 1ns/1ps
`default_nettype none
module pdc_channel_master (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Request pins, low-true
    output var logic [2:0] rowPinsN,
    output var logic [4:0] colPinsN,
    // Own drive onto the data lanes
    output var logic [8:0] laneADrvN,
    output var logic [8:0] laneBDrvN
);
    logic [31:0] cyc;
    // Idle request pins read as logic zero
    initial begin
        rowPinsN = 3'h7;
        colPinsN = 5'h1F;
        laneADrvN = 9'h155;
        laneBDrvN = 9'h0AA;
    end
    // Slot count from reset; lanes toggle so a stale value never passes for data
    always @(posedge core_clk) begin
        cyc <= rst_b ? cyc + 32'h1 : 32'h0;
        laneADrvN <= ~laneADrvN;
        laneBDrvN <= ~laneBDrvN;
    end
    // Wait for the edge just before a packet's first beat
    task automatic slot;
        do @(posedge core_clk); while (cyc[2:0] != 3'h6);
    endtask
    // Eight beats, highest bits first, inverted at the pins
    task automatic send_row(input logic [23:0] w);
        integer j;
        slot();
        for (j = 0; j < 8; j++) begin
            rowPinsN <= ~w[23 - 3 * j -: 3];
            @(posedge core_clk);
        end
        rowPinsN <= 3'h7;
    endtask
    // Command and companion share one start-framed slot
    task automatic send_col(input logic [39:0] w);
        integer j;
        slot();
        for (j = 0; j < 8; j++) begin
            colPinsN <= ~w[39 - 5 * j -: 5];
            @(posedge core_clk);
        end
        colPinsN <= 5'h1F;
    endtask
endmodule // pdc_channel_master
`default_nettype wire

// ===== pdc_command_path_test.sv
// Self-checking bench for the packet DRAM command path
`timescale 1ns/1ps
`default_nettype none
`include "pdc_regs.vh"
module pdc_command_path_test;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdData, rd, wv;
    logic [2:0] rowPinsN;
    logic [4:0] colPinsN, dev;
    logic [8:0] aOutN, aOeN, bOutN, bOeN, aDrvN, bDrvN, rowAddr;
    logic [1:0] me;
    logic [6:0] cv;
    logic [16:0] xp;
    logic [31:0] expOpen = 32'h0;
    logic [3:0] opTab [0:5] = '{`PDC_CCMD_IDLE, `PDC_CCMD_READ, `PDC_CCMD_WRITE,
        `PDC_CCMD_IDLE_CL, `PDC_CCMD_READ_CL, `PDC_CCMD_WRITE_CL};
    integer seed = 1;
    integer failures = 0;
    integer total_checks = 0;
    integer b, i, drv;
    // Lane wire: whoever enables wins; partner drives before reset settles
    wire logic [8:0] laneAN = rst_b ? ((aOeN & aDrvN) | (~aOeN & aOutN)) : aDrvN;
    wire logic [8:0] laneBN = rst_b ? ((bOeN & bDrvN) | (~bOeN & bOutN)) : bDrvN;

    always #4 core_clk = ~core_clk;

    pdc_command_path #(.WIDE18(0)) dut_u (.core_clk(core_clk), .rst_b(rst_b),
        .rowPinsN(rowPinsN), .colPinsN(colPinsN), .dataLaneAInN(laneAN),
        .dataLaneAOutN(aOutN), .dataLaneAOeN(aOeN), .dataLaneBInN(laneBN),
        .dataLaneBOutN(bOutN), .dataLaneBOeN(bOeN), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
    pdc_channel_master master_u (.core_clk(core_clk), .rst_b(rst_b), .rowPinsN(rowPinsN),
        .colPinsN(colPinsN), .laneADrvN(aDrvN), .laneBDrvN(bDrvN));
    // ----------------------------------------
    // Bench tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    task automatic done(input string what);
        $display("test %s finished", what);
    endtask
    // Write strobe is lowered by the read that always follows it
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic chk_open(input string what);
        logic [15:0] lo, hi;
        reg_read(`PDC_ADDR_OPENLO, lo);
        reg_read(`PDC_ADDR_OPENHI, hi);
        chk({hi, lo}, expOpen, what);
    endtask
    task automatic row(input logic [1:0] fr, input logic [3:0] dl, input logic [4:0] bk,
        input logic sel, input logic [10:0] low);
        master_u.send_row({fr, sel, dl, bk, 1'b0, low});
        repeat (3) @(posedge core_clk);
    endtask
    function automatic logic [39:0] col_pkt(input logic [4:0] d, input logic [4:0] bk,
        input logic [6:0] c, input logic [3:0] op, input logic [16:0] comp);
        return {1'b1, d, bk, c, 1'b0, op, comp};
    endfunction
    // Answer window covers decode, load and the whole burst
    task automatic col(input logic [39:0] w);
        drv = 0;
        master_u.send_col(w);
        repeat (24) begin
            @(posedge core_clk);
            #1;
            if (aOeN[0] === 1'b0)
                drv++;
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        reg_read(`PDC_ADDR_DEVNUM, rd);
        chk(rd, 0, "devnum reset");
        reg_read(`PDC_ADDR_REFROW, rd);
        chk(rd, 0, "refresh pointer reset");
        reg_read(4'hF, rd);
        chk(rd, 0, "unmapped read");
        chk({aOeN, bOeN}, 32'h3FFFF, "lanes released");
        chk_open("banks after reset");
        done("reset");
        // Random device number, upper bits ignored
        wv = $random(seed);
        dev = wv[4:0];
        me = {dev[4], ~dev[4]};
        reg_write(`PDC_ADDR_DEVNUM, wv);
        reg_read(`PDC_ADDR_DEVNUM, rd);
        chk(rd, {11'h000, dev}, "devnum echo");
        done("devnum");
        // Own, neighbour, foreign, unframed, broadcast and split-boundary opens
        b = 2 + 2 * ($unsigned($random(seed)) % 5);
        rowAddr = $random(seed);
        cv = $random(seed);
        row(me, dev[3:0], b[4:0], 1'b1, {2'b00, rowAddr});
        row(me, dev[3:0], b[4:0] + 5'd1, 1'b1, 11'h1FF);
        row(me, dev[3:0] ^ 4'h1, 5'd20, 1'b1, 11'h000);
        row(2'b00, dev[3:0], 5'd22, 1'b1, 11'h000);
        row(2'b11, ~dev[3:0], 5'd20, 1'b1, 11'h000);
        row(me, dev[3:0], 5'd15, 1'b1, 11'h000);
        row(me, dev[3:0], 5'd16, 1'b1, 11'h000);
        expOpen = (32'h1 << b) | 32'h0011_8000;
        chk_open("row opens");
        done("row open");
        // Reads of open, closed and foreign banks
        col(col_pkt(dev, b[4:0], cv, `PDC_CCMD_READ, 17'h0));
        chk(drv, 8, "read burst");
        col(col_pkt(dev, 5'd28, cv, `PDC_CCMD_READ, 17'h0));
        chk(drv, 0, "closed bank read");
        col(col_pkt(dev ^ 5'h01, b[4:0], cv, `PDC_CCMD_READ, 17'h0));
        chk(drv, 0, "foreign read");
        // Every column code, auto-close variants release the bank
        for (i = 0; i < 6; i++) begin
            row(me, dev[3:0], 5'd26, 1'b1, 11'h000);
            col(col_pkt(dev, 5'd26, cv, opTab[i], 17'h0));
            expOpen[26] = !opTab[i][2];
            chk(drv, (opTab[i][1:0] == 2'b01) ? 8 : 0, "column op drive");
            chk_open("column op close");
        end
        done("column ops");
        // Last write auto-closed its bank, so the buffer cannot retire yet
        reg_read(`PDC_ADDR_STATUS, rd);
        chk(rd, 1, "write buffer held");
        // Row close, extended close, then the freed neighbour opens
        row(me, dev[3:0], 5'd15, 1'b0, `PDC_ROP_CLOSE);
        xp = {1'b0, dev, 5'd16, 1'b0, `PDC_XCMD_CLOSE};
        col(col_pkt(dev, 5'd0, 7'h00, `PDC_CCMD_IDLE, xp));
        row(me, dev[3:0], b[4:0], 1'b0, `PDC_ROP_CLOSE);
        row(me, dev[3:0], b[4:0] + 5'd1, 1'b1, 11'h000);
        expOpen = 32'h0010_0000 | (32'h2 << b);
        chk_open("closes");
        done("close");
        // Broadcast refresh of the last bank steps the pointer
        row(2'b11, dev[3:0], 5'd31, 1'b0, `PDC_ROP_REFRESH);
        reg_read(`PDC_ADDR_REFROW, rd);
        chk(rd, 1, "refresh pointer step");
        done("refresh");
        end_of_test;
    end
    // Hang guard, well beyond the expected run length
    initial begin
        repeat (6000) @(posedge core_clk);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test;
    end
endmodule // pdc_command_path_test
`default_nettype wire
